// File: pwmdt_defs.svh
// register indices, field positions, reset values and timing figures
`ifndef PWMDT_DEFS_SVH
`define PWMDT_DEFS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PWMDT_IDX_TRIM_NT 8'h6D
`define PWMDT_IDX_TRIM_ET 8'h6E
`define PWMDT_IDX_STATUS 8'h70
`define PWMDT_ADDR_W 12

// ----------------------------------------------------------------------
// trim byte layout
// ----------------------------------------------------------------------
`define PWMDT_POL_HI_BIT 7
`define PWMDT_OFS_HI_MSB 6
`define PWMDT_OFS_HI_LSB 4
`define PWMDT_POL_LO_BIT 3
`define PWMDT_OFS_LO_MSB 2
`define PWMDT_OFS_LO_LSB 0
`define PWMDT_TRIM_RESET 8'h00

// ----------------------------------------------------------------------
// status word layout
// ----------------------------------------------------------------------
`define PWMDT_ST_NT_LSB 0
`define PWMDT_ST_ET_LSB 8
`define PWMDT_ST_PEND_BIT 16
`define PWMDT_ST_CLAMP_LSB 20
`define PWMDT_ST_CNT_LSB 24

// ----------------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------------
`define PWMDT_CLK_NS 20
`define PWMDT_TICK_NS 5
`define PWMDT_STEP_NS 5
`define PWMDT_MAX_NS 35
`define PWMDT_STEP_TICKS (`PWMDT_STEP_NS / `PWMDT_TICK_NS)

`endif

// File: pwmdt_pkg.sv
// types and helpers shared by the edge trim design
package pwmdt_pkg;

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef logic [7:0] pwmdt_byte_t;

   typedef struct packed {
      logic neg;          // 1 moves the edge earlier
      logic [2:0] code;   // offset in 5 ns steps
   } pwmdt_trim_s;

   // pick the upper or lower trim field out of a register byte
   function automatic pwmdt_trim_s pwmdt_unpack(input pwmdt_byte_t b,
                                               input logic upper);
      pwmdt_trim_s t;
      if (upper) begin
         t.neg = b[7];
         t.code = b[6:4];
      end else begin
         t.neg = b[3];
         t.code = b[2:0];
      end
      return t;
   endfunction

   // byte address of a register index
   function automatic logic [11:0] pwmdt_addr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

endpackage

// File: pwmdt_reg_if.sv
// carrier between the register slave and the trim core
`timescale 1ns/100ps
interface pwmdt_reg_if;
   pwmdt_pkg::pwmdt_byte_t trim_nt;   // live edge nine/ten byte
   pwmdt_pkg::pwmdt_byte_t trim_et;   // live edge eleven/twelve byte
   logic trim_wr;                     // pulse: a trim byte was written
   logic [31:0] status;               // core state for readback

   modport regs (output trim_nt, output trim_et, output trim_wr,
                 input status);
   modport core (input trim_nt, input trim_et, input trim_wr,
                 output status);
endinterface

// File: pwmdt_apb_regs.sv
// apb slave holding the two trim bytes and the status readback
`timescale 1ns/100ps
`include "pwmdt_defs.svh"
module pwmdt_apb_regs (
   input wire logic pclk,                            // bus clock
   input wire logic presetn,                         // async reset, low
   input wire logic [`PWMDT_ADDR_W-1:0] paddr,       // byte address
   input wire logic psel,                            // slave select
   input wire logic penable,                         // access phase
   input wire logic pwrite,                          // 1 write
   input wire logic [31:0] pwdata,                   // write data
   input wire logic [3:0] pstrb,                     // byte strobes
   output logic [31:0] prdata,                       // read data
   output logic pready,                              // transfer done
   output logic pslverr,                             // unmapped address
   pwmdt_reg_if.regs rif                             // core side
);
   logic hit_nt;
   logic hit_et;
   logic hit_st;
   logic mapped;
   logic take;

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   assign hit_nt = paddr == pwmdt_pkg::pwmdt_addr(`PWMDT_IDX_TRIM_NT);
   assign hit_et = paddr == pwmdt_pkg::pwmdt_addr(`PWMDT_IDX_TRIM_ET);
   assign hit_st = paddr == pwmdt_pkg::pwmdt_addr(`PWMDT_IDX_STATUS);
   assign mapped = hit_nt | hit_et | hit_st;
   // the completing edge of an access phase
   assign take = psel & penable & pready;

   // one wait state: pready rises one edge into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
      end
   end

   // read data is captured with pready so it is a flop output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & penable & ~pready & ~pwrite) begin
         if (hit_nt) begin
            prdata <= {24'h00_0000, rif.trim_nt};
         end else if (hit_et) begin
            prdata <= {24'h00_0000, rif.trim_et};
         end else if (hit_st) begin
            prdata <= rif.status;
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // write strobe is not registered: pending must rise with the byte,
   // or a boundary one edge later would apply it and still leave pending
   assign rif.trim_wr = take & pwrite & pstrb[0] & (hit_nt | hit_et);

   // trim bytes: only lane 0 carries data, upper lanes are ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rif.trim_nt <= `PWMDT_TRIM_RESET;
         rif.trim_et <= `PWMDT_TRIM_RESET;
      end else begin
         if (take & pwrite & pstrb[0] & hit_nt) begin
            rif.trim_nt <= pwdata[7:0];    // see R6
         end
         if (take & pwrite & pstrb[0] & hit_et) begin
            rif.trim_et <= pwdata[7:0];    // see R5
         end
      end
   end
endmodule

// File: pwmdt_edge_trim.sv
// one edge: nominal time moved by a signed 5 ns trim, saturating
`timescale 1ns/100ps
module pwmdt_edge_trim #(
   parameter int EDGE_W = 16                  // edge time width in ticks
) (
   input wire logic pclk,                     // core clock
   input wire logic presetn,                  // async reset, low
   input wire logic [EDGE_W-1:0] nominal,     // nominal edge, 5 ns ticks
   input wire pwmdt_pkg::pwmdt_trim_s trim,   // applied trim
   output logic [EDGE_W-1:0] adjusted,        // trimmed edge time
   output logic clamped                       // result saturated
);
   logic [EDGE_W:0] ofs;
   logic [EDGE_W:0] sum;
   logic [EDGE_W:0] dif;

   // ----------------------------------------------------------------------
   // arithmetic
   // ----------------------------------------------------------------------
   if (EDGE_W < 4) begin : g_bad_width
      $error("edge width must hold the largest trim");
   end

   // code is in steps; one step is a whole number of ticks
   assign ofs = (EDGE_W+1)'(trim.code) * (EDGE_W+1)'(`PWMDT_STEP_TICKS);
   assign sum = {1'b0, nominal} + ofs;
   assign dif = {1'b0, nominal} - ofs;

   // saturate rather than wrap, a wrapped edge would land a period away
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adjusted <= '0;
         clamped <= 1'b0;
      end else if (trim.neg) begin
         adjusted <= dif[EDGE_W] ? '0 : dif[EDGE_W-1:0];
         clamped <= dif[EDGE_W];
      end else begin
         adjusted <= sum[EDGE_W] ? '1 : sum[EDGE_W-1:0];
         clamped <= sum[EDGE_W];
      end
   end
endmodule

// File: pwmdt_top.sv
// edge dead-time trim block: apb registers, period-aligned apply, edges
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`include "pwmdt_defs.svh"

// What this block does
// R1 - edge nine moved by upper field, first byte
// R2 - edge ten moved by lower field, first byte
// R3 - edge eleven moved by upper field, second byte
// R4 - edge twelve moved by lower field, second byte
// R5 - edge eleven/twelve byte at index 6E
// R6 - edge nine/ten byte at index 6D
// R7 - new trims take effect at period start
module pwmdt_top #(
   parameter int EDGE_W = 16                      // edge time width, ticks
) (
   input wire logic pclk,                         // core clock, 50 MHz
   input wire logic presetn,                      // async reset, low
   input wire logic [`PWMDT_ADDR_W-1:0] paddr,    // apb byte address
   input wire logic psel,                         // apb select
   input wire logic penable,                      // apb access phase
   input wire logic pwrite,                       // apb direction
   input wire logic [31:0] pwdata,                // apb write data
   input wire logic [3:0] pstrb,                  // apb byte strobes
   output logic [31:0] prdata,                    // apb read data
   output logic pready,                           // apb ready
   output logic pslverr,                          // apb error
   input wire logic period_start,                 // pulse, new period
   input wire logic [EDGE_W-1:0] edge_nine_nom,   // nominal edge nine
   input wire logic [EDGE_W-1:0] edge_ten_nom,    // nominal edge ten
   input wire logic [EDGE_W-1:0] edge_eleven_nom, // nominal edge eleven
   input wire logic [EDGE_W-1:0] edge_twelve_nom, // nominal edge twelve
   output logic [EDGE_W-1:0] edge_nine_timing,    // trimmed edge nine
   output logic [EDGE_W-1:0] edge_ten_timing,     // trimmed edge ten
   output logic [EDGE_W-1:0] edge_eleven_timing,  // trimmed edge eleven
   output logic [EDGE_W-1:0] edge_twelve_timing,  // trimmed edge twelve
   output logic trim_pending                      // written, not yet applied
);

   // ----------------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------------

   // the largest trim is seven ticks, so four bits is the floor
   if (EDGE_W < 4) begin : g_bad_width
      $error("EDGE_W too small for the trim range");
   end

   // the trim table only maps onto whole ticks
   if ((`PWMDT_STEP_NS % `PWMDT_TICK_NS) != 0) begin : g_bad_tick
      $error("trim step is not a whole number of ticks");
   end

   // the top code must land on the largest documented offset
   if (7 * `PWMDT_STEP_NS != `PWMDT_MAX_NS) begin : g_bad_range
      $error("trim step and range disagree");
   end

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   pwmdt_reg_if rif ();

   // trim bytes as applied to the running period
   pwmdt_pkg::pwmdt_byte_t applied_nt;
   pwmdt_pkg::pwmdt_byte_t applied_et;

   // per-edge trims unpacked from the applied bytes
   pwmdt_pkg::pwmdt_trim_s trim_nine;
   pwmdt_pkg::pwmdt_trim_s trim_ten;
   pwmdt_pkg::pwmdt_trim_s trim_eleven;
   pwmdt_pkg::pwmdt_trim_s trim_twelve;

   // saturation flags from each edge
   logic clamp_nine;
   logic clamp_ten;
   logic clamp_eleven;
   logic clamp_twelve;

   // count of periods that took a new trim set
   logic [7:0] apply_count;
   logic next_pending;
   logic apply_now;

   // ----------------------------------------------------------------------
   // register slave
   // ----------------------------------------------------------------------

   // apb decode and the two live bytes live in the slave
   pwmdt_apb_regs u_regs (
      .pclk    (pclk),
      .presetn (presetn),
      .paddr   (paddr),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .pwdata  (pwdata),
      .pstrb   (pstrb),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .rif     (rif.regs)
   );

   // ----------------------------------------------------------------------
   // period-aligned apply
   // ----------------------------------------------------------------------

   // a period boundary always reloads, so a stale pending cannot stick
   assign apply_now = period_start;

   // a write in the boundary cycle keeps pending set: the reload at
   // that edge still sees the old byte, so the next period takes it
   always_comb begin
      next_pending = trim_pending;
      if (apply_now) begin
         next_pending = 1'b0;
      end
      if (rif.trim_wr) begin
         next_pending = 1'b1;
      end
   end

   // pending flag, set wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_pending <= 1'b0;
      end else begin
         trim_pending <= next_pending;
      end
   end

   // shadow bytes only move on a boundary, never mid-period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         applied_nt <= `PWMDT_TRIM_RESET;
         applied_et <= `PWMDT_TRIM_RESET;
      end else if (apply_now) begin
         applied_nt <= rif.trim_nt;   // see R7
         applied_et <= rif.trim_et;   // see R7
      end
   end

   // counts only boundaries that carried a pending change; wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apply_count <= 8'h00;
      end else if (apply_now && trim_pending) begin
         apply_count <= apply_count + 8'h01;
      end
   end

   // ----------------------------------------------------------------------
   // field split
   // ----------------------------------------------------------------------

   // upper nibble of each byte drives the odd-numbered edge
   assign trim_nine = pwmdt_pkg::pwmdt_unpack(applied_nt, 1'b1);   // see R1
   assign trim_ten = pwmdt_pkg::pwmdt_unpack(applied_nt, 1'b0);    // see R2
   assign trim_eleven = pwmdt_pkg::pwmdt_unpack(applied_et, 1'b1); // see R3
   assign trim_twelve = pwmdt_pkg::pwmdt_unpack(applied_et, 1'b0); // see R4

   // ----------------------------------------------------------------------
   // edge arithmetic
   // ----------------------------------------------------------------------

   // edge nine
   pwmdt_edge_trim #(
      .EDGE_W (EDGE_W)
   ) u_edge_nine (
      .pclk     (pclk),
      .presetn  (presetn),
      .nominal  (edge_nine_nom),
      .trim     (trim_nine),
      .adjusted (edge_nine_timing),      // see R1
      .clamped  (clamp_nine)
   );

   // edge ten
   pwmdt_edge_trim #(
      .EDGE_W (EDGE_W)
   ) u_edge_ten (
      .pclk     (pclk),
      .presetn  (presetn),
      .nominal  (edge_ten_nom),
      .trim     (trim_ten),
      .adjusted (edge_ten_timing),       // see R2
      .clamped  (clamp_ten)
   );

   // edge eleven
   pwmdt_edge_trim #(
      .EDGE_W (EDGE_W)
   ) u_edge_eleven (
      .pclk     (pclk),
      .presetn  (presetn),
      .nominal  (edge_eleven_nom),
      .trim     (trim_eleven),
      .adjusted (edge_eleven_timing),    // see R3
      .clamped  (clamp_eleven)
   );

   // edge twelve
   pwmdt_edge_trim #(
      .EDGE_W (EDGE_W)
   ) u_edge_twelve (
      .pclk     (pclk),
      .presetn  (presetn),
      .nominal  (edge_twelve_nom),
      .trim     (trim_twelve),
      .adjusted (edge_twelve_timing),    // see R4
      .clamped  (clamp_twelve)
   );

   // ----------------------------------------------------------------------
   // status readback
   // ----------------------------------------------------------------------

   // software sees what the running period uses, not what it wrote
   always_comb begin
      rif.status = 32'h0000_0000;
      rif.status[`PWMDT_ST_NT_LSB +: 8] = applied_nt;
      rif.status[`PWMDT_ST_ET_LSB +: 8] = applied_et;
      rif.status[`PWMDT_ST_PEND_BIT] = trim_pending;
      rif.status[`PWMDT_ST_CLAMP_LSB] = clamp_nine;
      rif.status[`PWMDT_ST_CLAMP_LSB + 1] = clamp_ten;
      rif.status[`PWMDT_ST_CLAMP_LSB + 2] = clamp_eleven;
      rif.status[`PWMDT_ST_CLAMP_LSB + 3] = clamp_twelve;
      rif.status[`PWMDT_ST_CNT_LSB +: 8] = apply_count;
   end

endmodule

// File: pwmdt_top_sva.sv
// assertion checker for the edge trim block, bound to its top module
`timescale 1ns/100ps
`include "pwmdt_defs.svh"
module pwmdt_sva #(
   parameter int EDGE_W = 16 // edge time width
) (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, low
   input wire logic [`PWMDT_ADDR_W-1:0] paddr, // apb
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pwrite, // apb
   input wire logic [31:0] pwdata, // apb
   input wire logic [3:0] pstrb, // apb
   input wire logic [31:0] prdata, // apb
   input wire logic pready, // apb
   input wire logic pslverr, // apb
   input wire logic period_start, // period pulse
   input wire logic [EDGE_W-1:0] edge_nine_nom, // nominal
   input wire logic [EDGE_W-1:0] edge_ten_nom, // nominal
   input wire logic [EDGE_W-1:0] edge_eleven_nom, // nominal
   input wire logic [EDGE_W-1:0] edge_twelve_nom, // nominal
   input wire logic [EDGE_W-1:0] edge_nine_timing, // trimmed
   input wire logic [EDGE_W-1:0] edge_ten_timing, // trimmed
   input wire logic [EDGE_W-1:0] edge_eleven_timing, // trimmed
   input wire logic [EDGE_W-1:0] edge_twelve_timing, // trimmed
   input wire logic trim_pending // pending flag
);
   localparam logic [11:0] A_NT = {2'b00, `PWMDT_IDX_TRIM_NT, 2'b00};
   localparam logic [11:0] A_ET = {2'b00, `PWMDT_IDX_TRIM_ET, 2'b00};
   localparam logic [11:0] A_ST = {2'b00, `PWMDT_IDX_STATUS, 2'b00};
   logic [7:0] live_nt, live_et, app_nt, app_et;
   logic up;
   logic wr_trim;

   // ----------------------------------------------------------------------
   // shadow of the live and applied trim bytes
   // ----------------------------------------------------------------------
   // a completed trim write with the low byte strobe set
   assign wr_trim = psel && penable && pready && pwrite && pstrb[0]
                    && (paddr == A_NT || paddr == A_ET);

   // live bytes follow bus writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         live_nt <= `PWMDT_TRIM_RESET;
         live_et <= `PWMDT_TRIM_RESET;
      end else if (wr_trim && paddr == A_NT) begin
         live_nt <= pwdata[7:0];
      end else if (wr_trim) begin
         live_et <= pwdata[7:0];
      end
   end

   // applied bytes copy the old live value, even on a coincident write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         app_nt <= `PWMDT_TRIM_RESET;
         app_et <= `PWMDT_TRIM_RESET;
      end else if (period_start) begin
         app_nt <= live_nt;
         app_et <= live_et;
      end
   end

   // $past is only trusted one edge after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up <= 1'b0;
      end else begin
         up <= 1'b1;
      end
   end

   // saturating trim of one nominal edge
   function automatic logic [EDGE_W-1:0] trim_f(
      input logic [EDGE_W-1:0] n, input logic [3:0] t);
      logic [EDGE_W:0] s;
      s = {1'b0, n} + (EDGE_W+1)'(t[2:0]);
      if (t[3]) begin
         return (n < EDGE_W'(t[2:0])) ? '0 : n - EDGE_W'(t[2:0]);
      end
      return s[EDGE_W] ? '1 : s[EDGE_W-1:0];
   endfunction

   // ----------------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_rd(logic [11:0] a);
      psel && penable && pready && !pwrite && paddr == a;
   endsequence

   a_edge_nine: assert property (up |-> edge_nine_timing ==
      trim_f($past(edge_nine_nom), $past(app_nt[7:4])))
      else $error("edge nine trim wrong");
   a_edge_ten: assert property (up |-> edge_ten_timing ==
      trim_f($past(edge_ten_nom), $past(app_nt[3:0])))
      else $error("edge ten trim wrong");
   a_edge_eleven: assert property (up |-> edge_eleven_timing ==
      trim_f($past(edge_eleven_nom), $past(app_et[7:4])))
      else $error("edge eleven trim wrong");
   a_edge_twelve: assert property (up |-> edge_twelve_timing ==
      trim_f($past(edge_twelve_nom), $past(app_et[3:0])))
      else $error("edge twelve trim wrong");
   a_read_et_byte: assert property (s_rd(A_ET) |->
      prdata == {24'h0, live_et} && !pslverr)
      else $error("edge eleven twelve byte readback wrong");
   a_read_nt_byte: assert property (s_rd(A_NT) |->
      prdata == {24'h0, live_nt} && !pslverr)
      else $error("edge nine ten byte readback wrong");
   a_pend_set: assert property (wr_trim |=> trim_pending)
      else $error("pending not raised by trim write");
   a_pend_clear: assert property (period_start && !wr_trim
      |=> !trim_pending) else $error("pending not cleared");
   a_one_wait: assert property (s_wait |=> pready && psel && penable)
      else $error("ready not given after one wait state");
   a_bad_addr: assert property (psel && penable && pready && paddr != A_NT
      && paddr != A_ET && paddr != A_ST |-> pslverr)
      else $error("unmapped access without error");
endmodule

bind pwmdt_top pwmdt_sva #(.EDGE_W(EDGE_W)) u_sva (.pclk(pclk),
   .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .period_start(period_start),
   .edge_nine_nom(edge_nine_nom), .edge_ten_nom(edge_ten_nom),
   .edge_eleven_nom(edge_eleven_nom), .edge_twelve_nom(edge_twelve_nom),
   .edge_nine_timing(edge_nine_timing), .edge_ten_timing(edge_ten_timing),
   .edge_eleven_timing(edge_eleven_timing),
   .edge_twelve_timing(edge_twelve_timing), .trim_pending(trim_pending));

// File: pwmdt_top_test.sv
// self-checking testbench for the edge trim block over apb
`timescale 1ns/100ps
`include "pwmdt_defs.svh"
module pwmdt_top_test;
   localparam logic [11:0] A_NT = {2'b00, `PWMDT_IDX_TRIM_NT, 2'b00};
   localparam logic [11:0] A_ET = {2'b00, `PWMDT_IDX_TRIM_ET, 2'b00};
   localparam logic [11:0] A_ST = {2'b00, `PWMDT_IDX_STATUS, 2'b00};
   localparam logic [15:0] NOM = 16'h0100;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, period_start = 0, trim_pending, err;
   logic [15:0] n9 = NOM, n10 = NOM, n11 = NOM, n12 = NOM;
   logic [15:0] e9, e10, e11, e12;
   int errors = 0, checks_done = 0;

   // ----------------------------------------------------------------------
   // clock, reset, device
   // ----------------------------------------------------------------------
   always #10 pclk = ~pclk;
   pwmdt_top #(.EDGE_W(16)) dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .period_start(period_start),
      .edge_nine_nom(n9), .edge_ten_nom(n10), .edge_eleven_nom(n11),
      .edge_twelve_nom(n12), .edge_nine_timing(e9), .edge_ten_timing(e10),
      .edge_eleven_timing(e11), .edge_twelve_timing(e12),
      .trim_pending(trim_pending));

   // ----------------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // one period start pulse, then wait until edges show the new trim
   task automatic pulse();
      @(posedge pclk);
      period_start <= 1'b1;
      @(posedge pclk);
      period_start <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------------
   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge pclk);
      errors++;
      close_out();
   end

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, then byte-only storage and ignored strobe
      apb(1'b0, A_NT, '0, 4'hF);
      check("nt reset", rd, 32'h0);
      apb(1'b0, A_ET, '0, 4'hF);
      check("et reset", rd, 32'h0);
      apb(1'b1, A_NT, 32'hFFFF_FF5A, 4'hF);
      @(posedge pclk);
      check("pending", trim_pending, 1'b1);
      apb(1'b1, A_ET, 32'h0000_0033, 4'hE);
      apb(1'b0, A_NT, '0, 4'hF);
      check("nt byte", rd, 32'h0000_005A);
      apb(1'b0, A_ET, '0, 4'hF);
      check("et unstrobed", rd, 32'h0);
      apb(1'b0, 12'h1BC, '0, 4'hF);
      check("bad addr err", err, 1'b1);
      check("bad addr data", rd, 32'h0);
      // every code in both directions, old trim kept until period start
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, A_NT, {24'h0, 1'b0, 3'(k), 1'b1, 3'(k)}, 4'hF);
         apb(1'b1, A_ET, {24'h0, 1'b1, 3'(k), 1'b0, 3'(k)}, 4'hF);
         check("held nine", e9, NOM + (k > 0 ? k - 1 : 0));
         pulse();
         check("pending clear", trim_pending, 1'b0);
         check("nine", e9, NOM + k);
         check("ten", e10, NOM - k);
         check("eleven", e11, NOM - k);
         check("twelve", e12, NOM + k);
      end
      // saturation at both ends of the edge range
      n9 <= 16'hFFFE;
      n10 <= 16'h0003;
      apb(1'b1, A_NT, 32'h0000_007F, 4'hF);
      pulse();
      check("nine top", e9, 16'hFFFF);
      check("ten floor", e10, 16'h0000);
      // status: a write is ignored without error; applied bytes 7F/F7,
      // nine and ten clamped, nine boundaries that carried a change
      apb(1'b1, A_ST, 32'hFFFF_FFFF, 4'hF);
      check("status wr err", err, 1'b0);
      apb(1'b0, A_ST, '0, 4'hF);
      check("status word", rd, 32'h0930_F77F);
      check("status rd err", err, 1'b0);
      close_out();
   end
endmodule
